// File: logic/tcs_timer.sv
// The placing of the registers and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module tcs_timer #(
  parameter int NUM_CH = 4,  // 4 full variant, 2 reduced
  parameter bit FULL   = 1   // split mode available when NUM_CH is 4
) (
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        hsel,
  input  wire logic [tcs_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic      [31:0]                 hrdata,
  output logic                             hreadyout,
  output logic                             hresp,
  input  wire logic [tcs_pkg::EV_N-1:0]    evt_i,
  output logic      [7:0]                  wave_o,
  output tcs_pkg::tcs_evt_t                evt_o,
  output logic      [1:0]                  hires_o
);
  import tcs_pkg::*;

  // register state
  tcs_ctrl_t   ctrl_r;          // mode and clock control
  logic [15:0] cnt_r;           // base counter
  logic [15:0] per_r;           // active period
  logic [15:0] perb_r;          // period buffer
  logic        ds_dn_r;         // dual-slope falling phase
  tcs_evt_t    sts_r;           // sticky flags
  logic [9:0]  pre_r;           // prescaler
  // bus state
  logic [ADDR_W-1:0] wa_r;      // write address held for data phase
  logic        wph_r;           // write data phase pending
  logic [31:0] rd_nxt;          // read mux
  logic        req, rd_req, wr_req;
  // event inputs after synchroniser
  logic [EV_N-1:0] ev_lvl, ev_rise, ev_fall;
  logic [1:0]  evb;             // quadrature b-phase index
  // counting
  logic [9:0]  msk;
  logic        pre_on, ev_clk, quad, updn, tick, down;
  logic        top, bot, ds;
  logic        lo_wrap, hi_wrap, wrap16, upd_lo, upd_hi;
  logic        restart, split, capt;
  // strobes
  logic        ctrl_wr, cnt_wr, per_wr, sts_wr;
  // channels
  logic [3:0]  hits, ovrs, wlo, whi, cc_wr, cc_rd, cap_stb;
  logic [15:0] ccv [4];
  tcs_evt_t    set;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // channel register decode, used for reads, writes and read side effects
  function automatic logic is_cc(input logic [ADDR_W-1:0] a, input int i);
    is_cc = a == A_CC0 + CC_STEP * ADDR_W'(i);
  endfunction : is_cc

  // ---------------- bus slave ----------------
  assign req    = hsel && hready && htrans == HT_NSEQ;
  assign rd_req = req && !hwrite;
  assign wr_req = req && hwrite;
  // one wait state when a read follows a write, so it sees the new value
  assign hreadyout = !(wph_r && hsel && htrans == HT_NSEQ && !hwrite);
  assign hresp     = 1'b0;  // always okay

  // write address phase is remembered; data lands at the next edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wph_r <= 1'b0;
      wa_r  <= '0;
    end else begin
      wph_r <= wr_req;
      if (wr_req) wa_r <= haddr;
    end
  end

  assign ctrl_wr = wph_r && wa_r == A_CTRL;
  assign cnt_wr  = wph_r && wa_r == A_CNT;
  assign per_wr  = wph_r && wa_r == A_PER;
  assign sts_wr  = wph_r && wa_r == A_STAT;

  // read mux; unmapped words read zero
  always_comb begin
    rd_nxt = '0;
    case (haddr)
      A_CTRL:  rd_nxt = ctrl_r;
      A_CNT:   rd_nxt = {16'h0000, cnt_r};
      A_PER:   rd_nxt = {16'h0000, perb_r};
      A_STAT:  rd_nxt = 32'(sts_r);
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (is_cc(haddr, i)) rd_nxt = {16'h0000, ccv[i]};
        end
      end
    endcase
  end

  // read data taken at the address edge, so it comes from a flop
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) hrdata <= '0;
    else if (rd_req) hrdata <= rd_nxt;
  end

  // control register; split forced off in the reduced variant
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= '0;
    end else if (ctrl_wr) begin
      ctrl_r       <= tcs_ctrl_t'(hwdata);
      ctrl_r.rsvd  <= '0;
      ctrl_r.split <= hwdata[$bits(tcs_ctrl_t) - $bits(ctrl_r.rsvd) - 9] && FULL && NUM_CH == 4;
    end
  end

  // ---------------- event inputs ----------------
  // noise cancelling is on whenever the block captures
  tcs_sync #(.N(EV_N), .NC(NC_LEN)) u_sync (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin_i   (evt_i),
    .nc_en   (capt),
    .lvl_o   (ev_lvl),
    .rise_o  (ev_rise),
    .fall_o  (ev_fall)
  );

  // ---------------- clock and direction ----------------
  assign split  = ctrl_r.split;
  assign capt   = ctrl_r.capture && !split;
  assign msk    = presc_mask(ctrl_r.clksel);
  assign pre_on = ctrl_r.clksel != CS_OFF && ctrl_r.clksel < CS_EVT;
  assign ev_clk = ctrl_r.clksel >= CS_EVT;
  assign quad   = !split && ctrl_r.evcnt == EC_QUAD;
  assign updn   = !split && ctrl_r.evcnt == EC_UPDN;
  assign evb    = ctrl_r.evsel + 2'h1;
  assign ds     = !split && !capt && ctrl_r.wg == WG_DS;

  // one tick source for both halves in split mode
  always_comb begin
    if (quad) tick = ev_rise[ctrl_r.evsel];
    else if (pre_on) tick = (pre_r & msk) == msk;
    else if (ev_clk) tick = ev_rise[ctrl_r.clksel[1:0]];
    else tick = 1'b0;
  end

  // direction: split forces down, events may steer it
  always_comb begin
    if (split) down = 1'b1;
    else if (quad) down = ev_lvl[evb];
    else if (updn) down = ev_lvl[ctrl_r.evsel];
    else if (ds) down = ds_dn_r;
    else down = ctrl_r.down;
  end

  // free-running prescaler, held clear while stopped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) pre_r <= '0;
    else if (!pre_on) pre_r <= '0;
    else pre_r <= pre_r + 10'h001;
  end

  // ---------------- counter ----------------
  assign top     = cnt_r >= per_r;
  assign bot     = cnt_r == '0;
  assign lo_wrap = tick && split && cnt_r[7:0] == '0;
  assign hi_wrap = tick && split && cnt_r[15:8] == '0;
  assign wrap16  = tick && !split && (ds ? ds_dn_r && bot : down ? bot : top);
  assign upd_lo  = split ? lo_wrap : wrap16;
  assign upd_hi  = split ? hi_wrap : wrap16;
  // frequency and pulse width capture restart the count
  assign restart = capt && (ctrl_r.evact == EA_FRQ || ctrl_r.evact == EA_PW) && ev_rise[ctrl_r.evsel];

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (cnt_wr) begin
      cnt_r <= hwdata[15:0];
    end else if (restart) begin
      cnt_r <= '0;
    end else if (tick) begin
      if (split) begin
        // two byte counters on one tick, each with its own period
        cnt_r[7:0]  <= cnt_r[7:0] == '0 ? per_r[7:0] : cnt_r[7:0] - 8'h01;
        cnt_r[15:8] <= cnt_r[15:8] == '0 ? per_r[15:8] : cnt_r[15:8] - 8'h01;
      end else if (ds) begin
        if (!ds_dn_r) cnt_r <= top ? cnt_r - 16'h0001 : cnt_r + 16'h0001;
        else cnt_r <= bot ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
      end else if (down) begin
        cnt_r <= bot ? per_r : cnt_r - 16'h0001;
      end else begin
        cnt_r <= top ? '0 : cnt_r + 16'h0001;
      end
    end
  end

  // dual-slope phase turns at top and bottom
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) ds_dn_r <= 1'b0;
    else if (!ds) ds_dn_r <= 1'b0;
    else if (tick && !ds_dn_r && top) ds_dn_r <= 1'b1;
    else if (tick && ds_dn_r && bot) ds_dn_r <= 1'b0;
  end

  // period: writes hit the buffer, halves copy at their own wrap
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      perb_r <= PER_RST;
      per_r  <= PER_RST;
    end else begin
      if (per_wr) perb_r <= hwdata[15:0];
      if (upd_lo) per_r[7:0] <= perb_r[7:0];
      if (upd_hi) per_r[15:8] <= perb_r[15:8];
    end
  end

  // ---------------- channels ----------------
  for (genvar i = 0; i < 4; i++) begin : g_ch
    // channel i watches event evsel+i, so each channel captures from its own event line
    logic [1:0] es;
    assign es       = ctrl_r.evsel + 2'(i);
    assign cap_stb[i] = capt && (ctrl_r.evact == EA_PW ? ev_fall[es] :
                                 ctrl_r.evact != 2'h0 && ev_rise[es]);
    assign cc_wr[i] = wph_r && is_cc(wa_r, i);
    assign cc_rd[i] = rd_req && is_cc(haddr, i);
    if (i < NUM_CH) begin : g_on
      tcs_chan u_ch (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .sw_wr   (cc_wr[i]),
        .sw_data (hwdata[15:0]),
        .sw_rd   (cc_rd[i]),
        .upd_lo  (upd_lo),
        .upd_hi  (upd_hi),
        .tick    (tick),
        .cap_stb (cap_stb[i]),
        .cnt     (cnt_r),
        .capture (capt),
        .wg      (ctrl_r.wg),
        .split   (split),
        .rd_val  (ccv[i]),
        .hit     (hits[i]),
        .ovr     (ovrs[i]),
        .wav_lo  (wlo[i]),
        .wav_hi  (whi[i])
      );
    end else begin : g_off
      // reduced variant: no logic for the upper channels
      assign ccv[i]  = '0;
      assign hits[i] = 1'b0;
      assign ovrs[i] = 1'b0;
      assign wlo[i]  = 1'b0;
      assign whi[i]  = 1'b0;
    end
  end

  assign wave_o  = {whi, wlo};
  assign hires_o = capt ? HR_OFF : ctrl_r.hires;

  // ---------------- flags and events ----------------
  // overflow bit doubles as underflow in split mode
  assign set.ovf = upd_lo;
  assign set.err = |ovrs;
  assign set.cc  = hits;

  // a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) sts_r <= '0;
    else sts_r <= tcs_evt_t'((sts_r & ~(sts_wr ? hwdata[$bits(tcs_evt_t)-1:0] : '0)) | set);
  end

  // one-cycle event outputs to the event system
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) evt_o <= '0;
    else evt_o <= set;
  end

  split_down_a: assert property (split && tick && !cnt_wr && cnt_r[7:0] != '0
    |=> cnt_r[7:0] == $past(cnt_r[7:0]) - 8'h01) else $error("low half not counting down");
  hi_down_a: assert property (split && tick && !cnt_wr && cnt_r[15:8] != '0
    |=> cnt_r[15:8] == $past(cnt_r[15:8]) - 8'h01) else $error("high half missed shared tick");
  up_wrap_a: assert property (!split && !ds && tick && !down && top && !cnt_wr && !restart
    |=> cnt_r == '0) else $error("up count did not wrap");
  down_load_a: assert property (!split && !ds && tick && down && bot && !cnt_wr && !restart
    |=> cnt_r == $past(per_r)) else $error("down count did not reload");
  per_hold_a: assert property (per_wr && !upd_lo && !upd_hi |=> per_r == $past(per_r))
    else $error("period bypassed buffer");
  per_load_a: assert property (!split && upd_lo |=> per_r == $past(perb_r))
    else $error("period not loaded at wrap");
  ovf_flag_a: assert property (upd_lo |=> sts_r.ovf && evt_o.ovf)
    else $error("overflow not reported");
  err_flag_a: assert property (|ovrs |=> sts_r.err && evt_o.err) else $error("error not reported");
  split_gate_a: assert property (!FULL |-> !split) else $error("split in reduced variant");
endmodule : tcs_timer
`default_nettype wire

// File: logic/tcs_pkg.sv
package tcs_pkg;
  localparam int         ADDR_W   = 8;      // byte address width
  localparam int         EV_N     = 4;      // event channel inputs
  localparam int         NC_LEN   = 4;      // noise cancel samples
  localparam logic [7:0] A_CTRL   = 8'h00;  // control word
  localparam logic [7:0] A_CNT    = 8'h04;  // counter value
  localparam logic [7:0] A_PER    = 8'h08;  // period buffer
  localparam logic [7:0] A_STAT   = 8'h0c;  // sticky flags, write one clears
  localparam logic [7:0] A_CC0    = 8'h10;  // first channel value
  localparam logic [7:0] CC_STEP  = 8'h04;  // channel register stride
  localparam logic [15:0] PER_RST = 16'hffff;
  localparam logic [1:0] HT_NSEQ  = 2'h2;   // ahb nonseq transfer
  localparam logic [3:0] CS_OFF   = 4'h0;   // counter stopped
  localparam logic [3:0] CS_EVT   = 4'h8;   // 8..15 select event clock, line from low two bits
  localparam logic [1:0] EC_UPDN  = 2'h1;   // event level is direction
  localparam logic [1:0] EC_QUAD  = 2'h2;   // quadrature decode
  localparam logic [1:0] EA_CAP   = 2'h1;   // input capture
  localparam logic [1:0] EA_FRQ   = 2'h2;   // frequency capture
  localparam logic [1:0] EA_PW    = 2'h3;   // pulse width capture
  localparam logic [1:0] HR_OFF   = 2'h0;   // hi-res off; 1 is 4x, 2 is 8x

  typedef enum logic [1:0] {WG_FRQ = 2'h0, WG_SS = 2'h1, WG_DS = 2'h2, WG_RSV = 2'h3} tcs_wg_t;

  typedef struct packed {
    logic [14:0] rsvd;
    logic [1:0]  hires;
    logic [1:0]  evcnt;
    logic [1:0]  evsel;
    logic [1:0]  evact;
    logic        split;
    logic        down;
    logic        capture;
    tcs_wg_t     wg;
    logic [3:0]  clksel;
  } tcs_ctrl_t;

  typedef struct packed {
    logic [3:0] cc;
    logic       err;
    logic       ovf;
  } tcs_evt_t;

  // prescaler tick mask for selections 1..7
  function automatic logic [9:0] presc_mask(input logic [3:0] cs);
    case (cs)
      4'h1:    presc_mask = 10'h000;
      4'h2:    presc_mask = 10'h001;
      4'h3:    presc_mask = 10'h003;
      4'h4:    presc_mask = 10'h007;
      4'h5:    presc_mask = 10'h03f;
      4'h6:    presc_mask = 10'h0ff;
      4'h7:    presc_mask = 10'h3ff;
      default: presc_mask = 10'h000;
    endcase
  endfunction : presc_mask
endpackage : tcs_pkg

// File: logic/tcs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_sync #(
  parameter int N  = 4,
  parameter int NC = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] pin_i,
  input  wire logic         nc_en,
  output logic      [N-1:0] lvl_o,
  output logic      [N-1:0] rise_o,
  output logic      [N-1:0] fall_o
);
  localparam int CW = $clog2(NC + 1);
  logic [N-1:0] s1_r, s2_r, s3_r;  // three-stage synchroniser

  // s1 feeds only s2, so metastability stays out of the filter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_bit
    logic          lv_r, rs_r, fl_r;
    logic [CW-1:0] nc_r;  // samples the new level has held
    // new level accepted once s2 and s3 agree, optionally after a run
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        lv_r <= 1'b0;
        rs_r <= 1'b0;
        fl_r <= 1'b0;
        nc_r <= '0;
      end else if (s2_r[i] == s3_r[i] && s3_r[i] != lv_r) begin
        if (!nc_en || nc_r == CW'(NC - 1)) begin
          lv_r <= s3_r[i];
          rs_r <= s3_r[i];
          fl_r <= !s3_r[i];
          nc_r <= '0;
        end else begin
          rs_r <= 1'b0;
          fl_r <= 1'b0;
          nc_r <= nc_r + CW'(1);
        end
      end else begin
        rs_r <= 1'b0;
        fl_r <= 1'b0;
        nc_r <= '0;
      end
    end
    assign lvl_o[i]  = lv_r;
    assign rise_o[i] = rs_r;
    assign fall_o[i] = fl_r;
  end
endmodule : tcs_sync
`default_nettype wire

// File: logic/tcs_chan.sv
`timescale 1ns/10ps
`default_nettype none
module tcs_chan (
  input  wire logic           sys_clk,
  input  wire logic           resetn,
  input  wire logic           sw_wr,
  input  wire logic [15:0]    sw_data,
  input  wire logic           sw_rd,
  input  wire logic           upd_lo,
  input  wire logic           upd_hi,
  input  wire logic           tick,
  input  wire logic           cap_stb,
  input  wire logic [15:0]    cnt,
  input  wire logic           capture,
  input  wire tcs_pkg::tcs_wg_t wg,
  input  wire logic           split,
  output logic      [15:0]    rd_val,
  output logic                hit,
  output logic                ovr,
  output logic                wav_lo,
  output logic                wav_hi
);
  import tcs_pkg::*;
  logic [15:0] act_r, buf_r;  // active and buffered value
  logic        bv_r;          // captured value not yet read
  logic        eq, lo_eq;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  assign eq     = cnt == act_r;
  assign lo_eq  = cnt[7:0] == act_r[7:0];
  assign rd_val = buf_r;

  // buffer stage: software writes or captures land here
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      buf_r <= '0;
      bv_r  <= 1'b0;
    end else if (capture && cap_stb) begin
      buf_r <= cnt;
      bv_r  <= 1'b1;
    end else if (sw_wr) begin
      buf_r <= sw_data;
    end else if (sw_rd) begin
      bv_r <= 1'b0;
    end
  end

  // active stage: halves load at their own update point; in capture mode the whole buffer loads on a capture over an unread value
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      act_r <= '0;
    end else if (capture) begin
      if (cap_stb && bv_r) act_r <= buf_r;
    end else begin
      if (upd_lo) act_r[7:0] <= buf_r[7:0];
      if (upd_hi) act_r[15:8] <= buf_r[15:8];
    end
  end

  // flag pulse and overrun; a capture over an unread one is an error
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      hit <= 1'b0;
      ovr <= 1'b0;
    end else begin
      hit <= capture ? cap_stb : tick && (split ? lo_eq : eq);
      ovr <= capture && cap_stb && bv_r && !sw_rd;
    end
  end

  // waveform outputs, quiet in capture mode
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wav_lo <= 1'b0;
      wav_hi <= 1'b0;
    end else if (capture) begin
      wav_lo <= 1'b0;
      wav_hi <= 1'b0;
    end else if (split) begin
      wav_lo <= cnt[7:0] < act_r[7:0];
      wav_hi <= cnt[15:8] < act_r[15:8];
    end else begin
      wav_hi <= 1'b0;
      if (wg == WG_FRQ) begin
        if (tick && eq) wav_lo <= !wav_lo;
      end else begin
        wav_lo <= cnt < act_r;
      end
    end
  end

  cap_buf_a: assert property (capture && cap_stb |=> buf_r == $past(cnt)) else $error("capture not buffered");
  mode_excl_a: assert property (capture |=> !wav_lo && !wav_hi) else $error("wave in capture mode");
  lo_only_a: assert property (split && !capture && tick && !lo_eq |=> !hit) else $error("high half flagged");
  ss_pwm_a: assert property (split && !capture |=> wav_hi == ($past(cnt[15:8]) < $past(act_r[15:8])))
    else $error("split pwm wrong");
  cmp_hit_a: assert property (tick && !capture && !split && eq |=> hit) else $error("match not flagged");
endmodule : tcs_chan
`default_nettype wire

// File: verification/tcs_evsrc.sv
`timescale 1ns/10ps
`default_nettype none
// event system stand-in: square pulses on event line 0
module tcs_evsrc (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       go,
  input  wire logic [3:0] num,
  output logic      [3:0] evt
);
  logic [3:0] left_r;  // rising edges still owed
  logic [3:0] ph_r;    // phase inside one pulse

  // sixteen-cycle pulses, long enough for the sync chain and the capture noise filter
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      left_r <= 4'h0;
      ph_r   <= 4'h0;
      evt    <= 4'h0;
    end else if (go) begin
      left_r <= num;
      ph_r   <= 4'h0;
    end else if (left_r != 4'h0) begin
      ph_r   <= ph_r + 4'h1;
      evt[0] <= (ph_r < 4'h8);     // high first half
      if (ph_r == 4'hf) begin
        left_r <= left_r - 4'h1;
      end
    end else begin
      evt <= 4'h0;                 // idle lines sit low
    end
  end
endmodule : tcs_evsrc
`default_nettype wire

// File: verification/tcs_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tcs_timer_tb;
  import tcs_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  evt_i;
  logic [7:0]  wave_o;
  tcs_evt_t    evt_o;
  logic [1:0]  hires_o;
  logic        go = 1'b0;
  logic [3:0]  num = 4'h5;
  logic [31:0] rd;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          o;
  int          c;
  int          w;
  int          h;
  int          er;

  always #2 sys_clk = ~sys_clk;  // 250 mhz

  tcs_timer #(.NUM_CH(4), .FULL(1)) dut (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt_i(evt_i), .wave_o(wave_o), .evt_o(evt_o),
    .hires_o(hires_o)
  );

  tcs_evsrc evs (.sys_clk(sys_clk), .resetn(resetn), .go(go), .num(num), .evt(evt_i));

  // one whole-word transfer; the master waits for the slave as long as it takes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HT_NSEQ;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdchk

  // counts overflow, channel 0, error and wave pulses over n cycles, sampled after each edge
  task automatic count(input int n);
    o = 0;
    c = 0;
    w = 0;
    h = 0;
    er = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (evt_o.ovf === 1'b1) o++;
      if (evt_o.cc[0] === 1'b1) c++;
      if (evt_o.err === 1'b1) er++;
      if (wave_o[0] === 1'b1) w++;
      if (wave_o[4] === 1'b1) h++;
    end
    @(posedge sys_clk);
  endtask : count

  task automatic t_reset;
    rdchk("ctrl", A_CTRL, 32'h0);
    rdchk("cnt", A_CNT, 32'h0);
    rdchk("per", A_PER, 32'hffff);
    rdchk("stat", A_STAT, 32'h0);
    rdchk("cc0", A_CC0, 32'h0);
    rdchk("gap", 8'h40, 32'h0);
    `CHK("resp", 1'b0, hresp)
    $display("reset values done");
  endtask : t_reset

  // down count reloads the active period; the first wrap makes it 3, then restart at zero: 4 cycles
  task automatic t_down;
    xfer(1'b1, A_PER, 32'h3);
    xfer(1'b1, A_CTRL, 32'h81);
    xfer(1'b1, A_CNT, 32'h0);
    repeat (8) @(posedge sys_clk);
    count(40);
    `CHK("down ovf", 10, o)
    `CHK("freq wave", 20, w)
    xfer(1'b1, A_CTRL, 32'h0);
    $display("down count done");
  endtask : t_down

  // up count with compare 1 and 4x hi-res: one overflow and one match every 4 cycles
  task automatic t_up;
    xfer(1'b1, A_CNT, 32'hffff);
    xfer(1'b1, A_CC0, 32'h1);
    xfer(1'b1, A_CTRL, 32'h8011);
    repeat (8) @(posedge sys_clk);
    count(40);
    `CHK("up ovf", 10, o)
    `CHK("cc0 hit", 10, c)
    `CHK("ss wave", 10, w)
    `CHK("hires", 2'h1, hires_o)
    xfer(1'b1, A_CTRL, 32'h0);
    // channels 1..3 hold compare 0, so they match each time the count passes zero
    rdchk("stat set", A_STAT, 32'h3d);
    xfer(1'b1, A_STAT, 32'h3f);
    rdchk("stat clr", A_STAT, 32'h0);
    $display("up count done");
  endtask : t_up

  // split with direction up still counts down: low byte period 2, high byte period 3
  task automatic t_split;
    xfer(1'b1, A_CNT, 32'h0);
    xfer(1'b1, A_PER, 32'h0302);
    xfer(1'b1, A_CC0, 32'h0201);
    xfer(1'b1, A_CTRL, 32'h101);
    repeat (8) @(posedge sys_clk);
    count(36);
    `CHK("split unf", 12, o)
    `CHK("split hit", 12, c)
    `CHK("split lo pwm", 12, w)
    `CHK("split hi pwm", 18, h)
    xfer(1'b1, A_CTRL, 32'h0);
    $display("split done");
  endtask : t_split

  // event line 0 as count clock: five edges, five counts
  task automatic t_event;
    xfer(1'b1, A_CNT, 32'h0);
    xfer(1'b1, A_CTRL, {28'h0, CS_EVT});
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (100) @(posedge sys_clk);
    rdchk("evt cnt", A_CNT, 32'h5);
    $display("event clock done");
  endtask : t_event

  // capture on rise with the counter stopped: five rises, four over an unread value
  task automatic t_cap;
    xfer(1'b1, A_CTRL, 32'h8240);
    xfer(1'b1, A_CNT, 32'h1234);
    xfer(1'b1, A_STAT, 32'h3f);
    `CHK("cap hires", 2'h0, hires_o)
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    count(100);
    `CHK("cap hits", 5, c)
    `CHK("cap errs", 4, er)
    `CHK("cap wave", 0, w)
    rdchk("cap stat", A_STAT, 32'h6);
    rdchk("cap val", A_CC0, 32'h1234);
    xfer(1'b1, A_CTRL, 32'h0);
    $display("capture done");
  endtask : t_cap

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_down();
    t_up();
    t_split();
    t_event();
    t_cap();
    wrap_up();
  end
endmodule : tcs_timer_tb
`default_nettype wire
